// file: logic/acdc_clock_config.sv
`timescale 1ns/1ps
`default_nettype none
module acdc_clock_config
  import acdc_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // register write port
  input wire logic WR_EN_I,
  input wire logic [7:0] WR_ADDR_I,
  input wire logic [7:0] WR_DATA_I,
  // mode inputs from the same clock domain
  input wire logic [3:0] MIXER_MODE_I,
  input wire logic [1:0] DAC_MODE_I,
  // clock pins
  input wire logic MCLK_I,
  input wire logic BCLK_I,
  input wire logic PLL_VCO_I,
  // outputs to the PLL core
  output logic PLL_EN_O,
  output logic PLL_REF_O,
  output logic PLL_FB_O,
  // outputs to the DAC clock generator
  output logic DAC_CLK_O,
  output logic [OSR_W-1:0] OSR_O
);

  // ***************************************************************
  // ratio decoding
  // ***************************************************************

  // half-step code: 1 divides by one, 0 divides by one unless zero_off is set, each code adds a half
  function automatic logic [RATIO_W-1:0] half_step_ratio(input logic [6:0] code,
                                                         input logic zero_off);
    logic [RATIO_W-1:0] r;
    r = RATIO_W'({2'b00, code}) + 9'h001;
    if (code == 7'h00)
      r = zero_off ? RATIO_OFF : RATIO_ONE;
    return r;
  endfunction : half_step_ratio

  // feedback code: integer steps, codes 1 to 10 clamp to ten, code 0 is off
  function automatic logic [RATIO_W-1:0] fb_ratio(input logic [FB_DIV_W-1:0] code);
    logic [RATIO_W-1:0] r;
    r = {code, 1'b0};
    if (code == 8'h00)
      r = RATIO_OFF;
    else if (code <= FB_MIN_CODE)
      r = FB_MIN_RATIO;
    return r;
  endfunction : fb_ratio

  function automatic logic [OSR_W-1:0] osr_of(input logic [1:0] mode);
    logic [OSR_W-1:0] r;
    case (mode)
      2'h0: r = OSR_125;
      2'h1: r = OSR_128;
      2'h2: r = OSR_64;
      2'h3: r = OSR_32;
      default: r = OSR_125;
    endcase
    return r;
  endfunction : osr_of

  // ***************************************************************
  // write-only register file
  // ***************************************************************

  logic [7:0] clk_cfg_q;
  logic [REF_DIV_W-1:0] ref_div_q;
  logic [FB_DIV_W-1:0] fb_div_q;
  logic [OUT_DIV_W-1:0] out_div_q;

  // no read path exists; unmapped offsets are ignored
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      clk_cfg_q <= RST_CLK_CFG;
      ref_div_q <= RST_REF_DIV;
      fb_div_q <= RST_FB_DIV;
      out_div_q <= RST_OUT_DIV;
    end
    else if (WR_EN_I)
    begin
      case (WR_ADDR_I)
        ADDR_CLK_CFG: clk_cfg_q <= WR_DATA_I;
        ADDR_REF_DIV: ref_div_q <= WR_DATA_I[REF_DIV_W-1:0];
        ADDR_FB_DIV: fb_div_q <= WR_DATA_I;
        ADDR_OUT_DIV: out_div_q <= WR_DATA_I[OUT_DIV_W-1:0];
        default: ;
      endcase
    end
  end

  logic cfg_halve;
  logic cfg_ref_bclk;
  logic cfg_audio_pll;
  logic [RDIV_W-1:0] cfg_rdiv;

  assign cfg_halve = clk_cfg_q[BIT_HALVE];
  assign cfg_ref_bclk = clk_cfg_q[BIT_REF_SEL];
  assign cfg_audio_pll = clk_cfg_q[BIT_AUDIO_SEL];
  assign cfg_rdiv = clk_cfg_q[RDIV_LSB +: RDIV_W];

  // ***************************************************************
  // pin synchronisers and edge detection
  // ***************************************************************

  // pins are sampled at 40 MHz, so a pin clock must stay well below
  // 20 MHz; both edges are used, which keeps half-step ratios exact
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] pin_edge;

  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {PLL_VCO_I, BCLK_I, MCLK_I};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign pin_edge = sync2_q ^ sync3_q;

  logic mclk_edge;
  logic bclk_edge;
  logic vco_edge;

  assign mclk_edge = pin_edge[0];
  assign bclk_edge = pin_edge[1];
  assign vco_edge = pin_edge[2];

  // ***************************************************************
  // PLL enable
  // ***************************************************************

  logic pll_run_d;
  logic pll_en_q;

  assign pll_run_d = clk_cfg_q[BIT_PLL_RUN] && (MIXER_MODE_I[3:2] == MODE_PLL_OK);

  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
      pll_en_q <= 1'b0;
    else
      pll_en_q <= pll_run_d;
  end

  // ***************************************************************
  // divider chain
  // ***************************************************************

  // stage 0 halves master, 1 reference, 2 feedback, 3 output, 4 R
  acdc_div_if u_if [NUM_DIV] ();

  genvar g;
  generate
    for (g = 0; g < NUM_DIV; g++)
    begin : g_div
      acdc_frac_div u_div (
        .CLK_SYS_I(CLK_SYS_I),
        .RST_I(RST_I),
        .div(u_if[g])
      );
    end
  endgenerate

  logic mclk_div_edge;
  logic pll_in_edge;
  logic pll_out_edge;
  logic audio_edge;
  logic use_pll_out;

  assign mclk_div_edge = u_if[0].edge_out;
  assign pll_in_edge = cfg_ref_bclk ? bclk_edge : mclk_div_edge;
  assign pll_out_edge = u_if[3].edge_out;
  // a bit clock reference is never fed to the DAC directly
  assign use_pll_out = cfg_audio_pll || cfg_ref_bclk;
  assign audio_edge = use_pll_out ? pll_out_edge : pll_in_edge;

  assign u_if[0].edge_in = mclk_edge;
  assign u_if[0].ratio = cfg_halve ? RATIO_TWO : RATIO_ONE;
  assign u_if[1].edge_in = pll_in_edge;
  assign u_if[1].ratio = half_step_ratio(ref_div_q, 1'b1);
  assign u_if[2].edge_in = vco_edge && pll_en_q;
  assign u_if[2].ratio = fb_ratio(fb_div_q);
  assign u_if[3].edge_in = vco_edge && pll_en_q;
  assign u_if[3].ratio = half_step_ratio({3'h0, out_div_q}, 1'b1);
  assign u_if[4].edge_in = audio_edge;
  assign u_if[4].ratio = half_step_ratio({3'h0, cfg_rdiv}, 1'b0);

  // ***************************************************************
  // outputs
  // ***************************************************************

  logic [OSR_W-1:0] osr_q;

  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
      osr_q <= RST_OSR;
    else
      osr_q <= osr_of(DAC_MODE_I);
  end

  assign PLL_EN_O = pll_en_q;
  assign PLL_REF_O = u_if[1].clk_out;
  assign PLL_FB_O = u_if[2].clk_out;
  assign DAC_CLK_O = u_if[4].clk_out;
  assign OSR_O = osr_q;

  // ***************************************************************
  // checks
  // ***************************************************************

  chk_cfg_write_taken: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (WR_EN_I && WR_ADDR_I == ADDR_CLK_CFG) |=> (clk_cfg_q == $past(WR_DATA_I)))
    else $error("clock configuration write lost");

  chk_reset_passthru: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    $past(RST_I) |-> (clk_cfg_q == RST_CLK_CFG && !use_pll_out
                      && u_if[4].ratio == RATIO_ONE))
    else $error("reset state does not pass master clock through");

  chk_halve_ratio: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (WR_EN_I && WR_ADDR_I == ADDR_CLK_CFG && WR_DATA_I[BIT_HALVE])
    |=> (u_if[0].ratio == RATIO_TWO))
    else $error("master clock not halved");

  chk_ref_source: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    cfg_ref_bclk |-> (u_if[1].edge_in == bclk_edge))
    else $error("reference divider not fed from bit clock");

  chk_audio_direct: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (!cfg_ref_bclk && !cfg_audio_pll && mclk_div_edge) |-> u_if[4].edge_in)
    else $error("audio clock not taken from PLL input");

  chk_bclk_via_pll: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    cfg_ref_bclk |-> (u_if[4].edge_in == pll_out_edge))
    else $error("bit clock reference reached DAC without PLL");

  chk_pll_enable: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    ##1 (PLL_EN_O == $past(pll_run_d)))
    else $error("PLL enable does not follow run bit and mode");

  chk_rdiv_top: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (cfg_rdiv == 4'hF) |-> (u_if[4].ratio == 9'h010))
    else $error("R divider top code not divide by eight");

  chk_fb_floor: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (fb_div_q != 8'h00 && fb_div_q <= FB_MIN_CODE) |-> (u_if[2].ratio == FB_MIN_RATIO))
    else $error("feedback divider below ten");

  chk_osr_code: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (DAC_MODE_I == 2'h3) |=> (OSR_O == OSR_32))
    else $error("oversampling ratio wrong for mode three");

  // a stray write must leave every register as it was
  chk_unmapped_ignored: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (WR_EN_I && WR_ADDR_I != ADDR_CLK_CFG && WR_ADDR_I != ADDR_REF_DIV
     && WR_ADDR_I != ADDR_FB_DIV && WR_ADDR_I != ADDR_OUT_DIV)
    |=> (clk_cfg_q == $past(clk_cfg_q) && ref_div_q == $past(ref_div_q)
         && fb_div_q == $past(fb_div_q) && out_div_q == $past(out_div_q)))
    else $error("write to an unmapped offset changed a register");

  chk_ref_off: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (ref_div_q == 7'h00) |-> (u_if[1].ratio == RATIO_OFF))
    else $error("reference divider not off at code zero");

  chk_out_half: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (out_div_q == 4'hE) |-> (u_if[3].ratio == 9'h00F))
    else $error("output divider code fourteen not seven and a half");

  chk_fb_gated: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !pll_en_q |-> (!u_if[2].edge_in && !u_if[3].edge_in))
    else $error("PLL dividers counted while PLL disabled");

  chk_ref_master: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !cfg_ref_bclk |-> (u_if[1].edge_in == mclk_div_edge))
    else $error("reference divider not fed from master clock");

endmodule : acdc_clock_config
`default_nettype wire

// file: logic/acdc_pkg.sv
`default_nettype none
// ***************************************************************
// constants of the audio clock divider configuration block
// ***************************************************************
package acdc_pkg;

  // register offsets (8-bit write-only registers)
  localparam logic [7:0] ADDR_CLK_CFG = 8'h09;
  localparam logic [7:0] ADDR_REF_DIV = 8'h0A;
  localparam logic [7:0] ADDR_FB_DIV = 8'h0B;
  localparam logic [7:0] ADDR_OUT_DIV = 8'h0D;

  // clock_source_config field positions, then register field widths
  localparam int BIT_HALVE = 0;
  localparam int BIT_REF_SEL = 1;
  localparam int BIT_AUDIO_SEL = 2;
  localparam int BIT_PLL_RUN = 3;
  localparam int RDIV_LSB = 4;
  localparam int RDIV_W = 4;
  localparam int REF_DIV_W = 7;
  localparam int FB_DIV_W = 8;
  localparam int OUT_DIV_W = 4;

  // values after reset: master clock straight to the clock generator
  localparam logic [7:0] RST_CLK_CFG = 8'h00;
  localparam logic [REF_DIV_W-1:0] RST_REF_DIV = 7'h00;
  localparam logic [FB_DIV_W-1:0] RST_FB_DIV = 8'h00;
  localparam logic [OUT_DIV_W-1:0] RST_OUT_DIV = 4'h0;

  // divider ratios are counted in input edges (two edges per input period)
  localparam int RATIO_W = 9;
  localparam logic [RATIO_W-1:0] RATIO_OFF = 9'h000;
  localparam logic [RATIO_W-1:0] RATIO_ONE = 9'h002;
  localparam logic [RATIO_W-1:0] RATIO_TWO = 9'h004;
  localparam logic [FB_DIV_W-1:0] FB_MIN_CODE = 8'h0A;
  localparam logic [RATIO_W-1:0] FB_MIN_RATIO = 9'h014;

  // mixer modes 12 to 15 share the two top code bits
  localparam logic [1:0] MODE_PLL_OK = 2'h3;

  // oversampling ratios
  localparam int OSR_W = 8;
  localparam logic [OSR_W-1:0] OSR_125 = 8'h7D;
  localparam logic [OSR_W-1:0] OSR_128 = 8'h80;
  localparam logic [OSR_W-1:0] OSR_64 = 8'h40;
  localparam logic [OSR_W-1:0] OSR_32 = 8'h20;
  localparam logic [OSR_W-1:0] RST_OSR = 8'h7D;

  localparam int NUM_DIV = 5;

endpackage : acdc_pkg
`default_nettype wire

// file: logic/acdc_div_if.sv
`timescale 1ns/1ps
`default_nettype none
// ***************************************************************
// one divider stage: edge pulses in, divided clock out
// ***************************************************************
interface acdc_div_if;
  import acdc_pkg::*;
  logic edge_in;
  logic [RATIO_W-1:0] ratio;
  logic clk_out;
  logic edge_out;
  modport div_mp (input edge_in, input ratio, output clk_out, output edge_out);
  modport ctl_mp (output edge_in, output ratio, input clk_out, input edge_out);
endinterface : acdc_div_if
`default_nettype wire

// file: logic/acdc_frac_div.sv
`timescale 1ns/1ps
`default_nettype none
// ***************************************************************
// half-step divider: period of ratio input edges, odd ratios give
// a high phase one edge longer than the low phase
// ***************************************************************
module acdc_frac_div
  import acdc_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // divider stage
  acdc_div_if.div_mp div
);

  logic [RATIO_W-1:0] ratio_q;
  logic [RATIO_W-1:0] cnt_q;
  logic clk_q;
  logic edge_q;
  logic wrap;
  logic [RATIO_W-1:0] nxt_cnt;
  logic [RATIO_W-1:0] nxt_ratio;
  logic [RATIO_W-1:0] hi_len;
  logic clk_d;

  // a new ratio is taken only at the end of a period, so no runt phase
  always_comb
  begin
    wrap = (ratio_q == RATIO_OFF) || (cnt_q >= ratio_q - 9'h001);
    nxt_cnt = wrap ? 9'h000 : cnt_q + 9'h001;
    nxt_ratio = wrap ? div.ratio : ratio_q;
    hi_len = RATIO_W'((nxt_ratio + 9'h001) >> 1);
    clk_d = (nxt_ratio != RATIO_OFF) && (nxt_cnt < hi_len);
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ratio_q <= RATIO_OFF;
      cnt_q <= 9'h000;
      clk_q <= 1'b0;
      edge_q <= 1'b0;
    end
    else
    begin
      edge_q <= div.edge_in && (clk_d != clk_q);
      if (div.edge_in)
      begin
        ratio_q <= nxt_ratio;
        cnt_q <= nxt_cnt;
        clk_q <= clk_d;
      end
    end
  end

  assign div.clk_out = clk_q;
  assign div.edge_out = edge_q;

  chk_off_held_low: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (ratio_q == RATIO_OFF) |-> !clk_q)
    else $error("divider switched off but output not low");

  chk_period_wrap: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    (div.edge_in && ratio_q != RATIO_OFF && cnt_q == ratio_q - 9'h001)
    |=> (cnt_q == 9'h000 && clk_q == (ratio_q != RATIO_OFF)))
    else $error("divider did not restart its period");

endmodule : acdc_frac_div
`default_nettype wire

// file: test/acdc_clk_src.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// clock pin source, held low while stopped
// ********
module acdc_clk_src #(
  parameter int PHASE_NS = 7
) (
  // control
  input wire logic run_i,
  input var int half_ns_i,
  // clock pin
  output var logic clk_o
);
  // the phase offset keeps pin edges clear of the system clock edges
  initial
  begin
    clk_o = 1'b0;
    #(PHASE_NS);
    forever
    begin
      if (run_i)
      begin
        #(half_ns_i);
        clk_o = ~clk_o;
      end
      else
      begin
        clk_o = 1'b0;
        @(posedge run_i);
      end
    end
  end
endmodule : acdc_clk_src
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import acdc_pkg::*;
  // ********
  // signals and instances
  // ********
  logic clk;
  logic rst;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [3:0] mix_mode;
  logic [1:0] dac_mode;
  logic b_run;
  logic src_run;
  int m_half;
  int b_half;
  int v_half;
  logic mclk;
  logic bclk;
  logic vco;
  logic pll_en;
  logic pll_ref;
  logic pll_fb;
  logic dac_clk;
  logic [OSR_W-1:0] osr;
  int err_total;
  int total_checks;

  // half periods of 4, 5 and 3 system cycles
  acdc_clk_src #(.PHASE_NS(7)) i_acdc_clk_src_m (.run_i(src_run), .half_ns_i(m_half),
    .clk_o(mclk));
  acdc_clk_src #(.PHASE_NS(3)) i_acdc_clk_src_b (.run_i(b_run), .half_ns_i(b_half),
    .clk_o(bclk));
  acdc_clk_src #(.PHASE_NS(17)) i_acdc_clk_src_v (.run_i(src_run), .half_ns_i(v_half),
    .clk_o(vco));

  acdc_clock_config i_acdc_clock_config (
    .CLK_SYS_I(clk), .RST_I(rst), .WR_EN_I(wr_en), .WR_ADDR_I(wr_addr), .WR_DATA_I(wr_data),
    .MIXER_MODE_I(mix_mode), .DAC_MODE_I(dac_mode), .MCLK_I(mclk), .BCLK_I(bclk),
    .PLL_VCO_I(vco), .PLL_EN_O(pll_en), .PLL_REF_O(pll_ref), .PLL_FB_O(pll_fb),
    .DAC_CLK_O(dac_clk), .OSR_O(osr));

  // ********
  // shared tasks
  // ********
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  // every step ends just after a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic step(inout int n);
    cyc(1);
    n++;
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    cyc(1);
    wr_en = 1'b0;
    cyc(2);
  endtask : wr

  function automatic logic sig(input int s);
    case (s)
      0: return dac_clk;
      1: return pll_ref;
      default: return pll_fb;
    endcase
  endfunction : sig

  task automatic measure(input int s, output int per, output int hi);
    int n;
    int t0;
    n = 0;
    while (sig(s) !== 1'b0 && n < 900) step(n);
    while (sig(s) !== 1'b1 && n < 900) step(n);
    t0 = n;
    while (sig(s) === 1'b1 && n < 900) step(n);
    hi = n - t0;
    while (sig(s) === 1'b0 && n < 900) step(n);
    per = n - t0;
    if (n >= 900)
    begin
      check(n, 0);
      give_verdict();
    end
  endtask : measure

  // two periods are let pass so that a ratio change has settled in every stage
  task automatic chk_per(input int s, input int ep, input int eh);
    int per;
    int hi;
    repeat (3) measure(s, per, hi);
    check(per, ep);
    check(hi, eh);
  endtask : chk_per

  task automatic chk_still(input int s);
    int cnt;
    logic last;
    cnt = 0;
    cyc(100);
    last = sig(s);
    repeat (200)
    begin
      cyc(1);
      if (sig(s) !== last) cnt++;
      last = sig(s);
    end
    check(cnt, 0);
  endtask : chk_still

  // ********
  // scenarios
  // ********
  task automatic t_reset;
    cyc(2);
    check(osr, 8'h7D);
    check(dac_clk, 1'b0);
    check(pll_en, 1'b0);
    cyc(1);
    rst = 1'b0;
    chk_per(0, 8, 4);
    $display("done reset");
  endtask : t_reset

  task automatic t_osr;
    logic [7:0] tbl [4] = '{8'h7D, 8'h80, 8'h40, 8'h20};
    for (int i = 0; i < 4; i++)
    begin
      dac_mode = i[1:0];
      cyc(2);
      check(osr, tbl[i]);
    end
    $display("done oversampling");
  endtask : t_osr

  task automatic t_rdiv;
    int e;
    for (int c = 0; c < 16; c++)
    begin
      e = (c == 0) ? 2 : c + 1;
      wr(ADDR_CLK_CFG, {c[3:0], 4'h0});
      chk_per(0, e * 4, (e + 1) / 2 * 4);
    end
    wr(ADDR_CLK_CFG, 8'h01);
    chk_per(0, 16, 8);
    wr(ADDR_CLK_CFG, 8'h31);
    chk_per(0, 32, 16);
    wr(8'h0C, 8'hF0);
    chk_per(0, 32, 16);
    $display("done r divider");
  endtask : t_rdiv

  task automatic t_ref;
    b_run = 1'b1;
    wr(ADDR_CLK_CFG, 8'h00);
    wr(ADDR_REF_DIV, 8'h03);
    chk_per(1, 16, 8);
    wr(ADDR_CLK_CFG, 8'h02);
    chk_per(1, 20, 10);
    wr(ADDR_REF_DIV, 8'h02);
    chk_per(1, 15, 10);
    wr(ADDR_REF_DIV, 8'h00);
    chk_still(1);
    b_run = 1'b0;
    $display("done reference");
  endtask : t_ref

  task automatic t_pll;
    logic [3:0] md [8] = '{4'h0, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
    logic [7:0] nc [3] = '{8'h01, 8'h0A, 8'h0B};
    int nr [3] = '{10, 10, 11};
    wr(ADDR_CLK_CFG, 8'h0C);
    for (int i = 0; i < 8; i++)
    begin
      mix_mode = md[i];
      cyc(3);
      check(pll_en, i >= 4);
    end
    wr(ADDR_OUT_DIV, 8'h03);
    chk_per(0, 12, 6);
    wr(ADDR_CLK_CFG, 8'h3C);
    chk_per(0, 24, 12);
    wr(ADDR_CLK_CFG, 8'h0C);
    wr(ADDR_OUT_DIV, 8'h0E);
    chk_per(0, 45, 24);
    wr(ADDR_CLK_CFG, 8'h0A);
    chk_per(0, 45, 24);
    wr(ADDR_CLK_CFG, 8'h08);
    chk_per(0, 8, 4);
    wr(ADDR_CLK_CFG, 8'h0C);
    wr(ADDR_OUT_DIV, 8'h00);
    chk_still(0);
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_FB_DIV, nc[i]);
      chk_per(2, nr[i] * 6, nr[i] * 3);
    end
    wr(ADDR_FB_DIV, 8'h00);
    chk_still(2);
    wr(ADDR_FB_DIV, 8'h0B);
    wr(ADDR_CLK_CFG, 8'h04);
    check(pll_en, 1'b0);
    chk_still(2);
    $display("done pll path");
  endtask : t_pll

  // ********
  // clock and main sequence
  // ********
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    err_total = 0;
    total_checks = 0;
    rst = 1'b1;
    wr_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    mix_mode = 4'h0;
    dac_mode = 2'h0;
    b_run = 1'b0;
    src_run = 1'b1;
    m_half = 100;
    b_half = 125;
    v_half = 75;
    #1;
    t_reset();
    t_osr();
    t_rdiv();
    t_ref();
    t_pll();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
